//--- hdl/adc_conversion_host_interface.sv
// conversion sequencer with parallel, serial and AHB-Lite host access
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module adc_conversion_host_interface
#(
	parameter bit high_range_variant = 1'b1
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic interface_mode_strap,
	input wire logic hw_start_strobe_n,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [11:0] parallel_bus_in,
	output logic [11:0] parallel_bus_out,
	output logic parallel_bus_oe,
	input wire logic serial_clock,
	input wire logic read_frame_n,
	input wire logic write_frame_n,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	input wire logic [11:0] core_result,
	output logic track_hold,
	output logic eoc_n,
	output logic power_down,
	output logic [2:0] mux_channel
);
	// -----------------------------------------------------------------
	// state and decoded events
	// -----------------------------------------------------------------
	adc_if_pkg::state_t r_reg;
	adc_if_pkg::state_t r_next;
	logic [4:0] acq_cyc;
	logic mode_par;
	logic hw_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic rfs_fall;
	logic rfs_rise;
	logic tfs_fall;
	logic wr_rise;
	logic ahb_ctrl_wr;
	logic ctrl_ld;
	logic [adc_if_pkg::CTRL_W-1:0] ctrl_val;
	logic sw_go;
	logic hw_go;
	logic [adc_if_pkg::RES_W-1:0] coded;

	assign acq_cyc = high_range_variant ? adc_if_pkg::ACQ_HIGH_CYC : adc_if_pkg::ACQ_LOW_CYC;

	always_comb
	begin
		r_next = r_reg;
		// pins pass two flops before use; sy3 only delays sy2 for edges
		r_next.sy1 = {interface_mode_strap, write_strobe_n, read_strobe_n, chip_select_n, serial_data_in,
			write_frame_n, read_frame_n, serial_clock, hw_start_strobe_n};
		r_next.sy2 = r_reg.sy1;
		r_next.sy3 = r_reg.sy2;
		r_next.db_s1 = parallel_bus_in[adc_if_pkg::CTRL_W-1:0];
		r_next.db_s2 = r_reg.db_s1;

		mode_par = r_reg.sy2[adc_if_pkg::P_MODE];
		hw_rise = r_reg.sy2[adc_if_pkg::P_START] & ~r_reg.sy3[adc_if_pkg::P_START];
		sclk_rise = r_reg.sy2[adc_if_pkg::P_SCLK] & ~r_reg.sy3[adc_if_pkg::P_SCLK];
		sclk_fall = ~r_reg.sy2[adc_if_pkg::P_SCLK] & r_reg.sy3[adc_if_pkg::P_SCLK];
		rfs_fall = ~r_reg.sy2[adc_if_pkg::P_RFS] & r_reg.sy3[adc_if_pkg::P_RFS];
		rfs_rise = r_reg.sy2[adc_if_pkg::P_RFS] & ~r_reg.sy3[adc_if_pkg::P_RFS];
		tfs_fall = ~r_reg.sy2[adc_if_pkg::P_TFS] & r_reg.sy3[adc_if_pkg::P_TFS];
		wr_rise = r_reg.sy2[adc_if_pkg::P_WR] & ~r_reg.sy3[adc_if_pkg::P_WR] & ~r_reg.sy3[adc_if_pkg::P_CS];
		ahb_ctrl_wr = r_reg.a_sel & r_reg.a_write & (r_reg.a_addr == adc_if_pkg::CTRL_OFS);
		ctrl_ld = 1'b0;
		ctrl_val = r_reg.ctrl;

		// -------------------------------------------------------------
		// parallel bus
		// -------------------------------------------------------------
		if (mode_par && wr_rise)
		begin
			ctrl_ld = 1'b1;
			ctrl_val = r_reg.db_s2;
		end
		r_next.db_oe = mode_par & ~r_reg.sy2[adc_if_pkg::P_CS] & ~r_reg.sy2[adc_if_pkg::P_RD];

		// -------------------------------------------------------------
		// serial link, clock edges found by sampling
		// -------------------------------------------------------------
		if (mode_par)
		begin
			r_next.sdo_oe = 1'b0;
		end
		else if (rfs_fall)
		begin
			// snapshot so a write in the same frame cannot alter the word
			r_next.rd_shift = {r_reg.ctrl[adc_if_pkg::FMT_BIT], r_reg.ctrl[adc_if_pkg::CH_MSB:adc_if_pkg::CH_LSB],
				r_reg.result};
			r_next.rd_cnt = adc_if_pkg::CNT_ZERO;
		end
		else if (rfs_rise)
		begin
			r_next.sdo_oe = 1'b0;
		end
		else if (sclk_rise && !r_reg.sy2[adc_if_pkg::P_RFS])
		begin
			if (r_reg.rd_cnt == adc_if_pkg::SER_RD_BITS)
			begin
				r_next.sdo_oe = 1'b0;
			end
			else
			begin
				r_next.sdo = r_reg.rd_shift[adc_if_pkg::SER_RD_W-1];
				r_next.rd_shift = {r_reg.rd_shift[adc_if_pkg::SER_RD_W-2:0], 1'b0};
				r_next.sdo_oe = 1'b1;
				r_next.rd_cnt = r_reg.rd_cnt + adc_if_pkg::CNT_ONE;
			end
		end

		if (!mode_par && tfs_fall)
		begin
			r_next.wr_cnt = 3'h0;
		end
		else if (!mode_par && sclk_fall && !r_reg.sy2[adc_if_pkg::P_TFS] && r_reg.wr_cnt != adc_if_pkg::SER_WR_BITS)
		begin
			// later clocks leave the count saturated and the bits unused
			r_next.wr_shift = {r_reg.wr_shift[adc_if_pkg::CTRL_W-2:0], r_reg.sy2[adc_if_pkg::P_SDI]};
			r_next.wr_cnt = r_reg.wr_cnt + 3'h1;
			if (r_reg.wr_cnt == adc_if_pkg::SER_WR_LAST)
			begin
				ctrl_ld = 1'b1;
				ctrl_val = {r_reg.wr_shift[adc_if_pkg::CTRL_W-2:0], r_reg.sy2[adc_if_pkg::P_SDI]};
			end
		end

		// -------------------------------------------------------------
		// AHB-Lite slave, zero wait states, last writer wins
		// -------------------------------------------------------------
		if (ahb_ctrl_wr)
		begin
			ctrl_ld = 1'b1;
			ctrl_val = hwdata[adc_if_pkg::CTRL_W-1:0];
		end
		r_next.a_sel = hsel & htrans[1] & hready;
		r_next.a_write = hwrite;
		r_next.a_addr = haddr[7:0];
		r_next.hrdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			unique case (haddr[7:0])
				adc_if_pkg::CTRL_OFS: r_next.hrdata[adc_if_pkg::CTRL_W-1:0] = r_reg.ctrl;
				adc_if_pkg::RESULT_OFS: r_next.hrdata[adc_if_pkg::RES_W-1:0] = r_reg.result;
				adc_if_pkg::STATUS_OFS:
				begin
					r_next.hrdata[adc_if_pkg::ST_BUSY_BIT] = r_reg.conv != adc_if_pkg::CS_IDLE;
					r_next.hrdata[adc_if_pkg::ST_STATE_MSB:adc_if_pkg::ST_STATE_LSB] = r_reg.conv;
					r_next.hrdata[adc_if_pkg::ST_MODE_BIT] = mode_par;
					r_next.hrdata[adc_if_pkg::ST_HOLD_BIT] = r_reg.conv == adc_if_pkg::CS_CONV;
					r_next.hrdata[adc_if_pkg::ST_STBY_BIT] = r_reg.ctrl[adc_if_pkg::STBY_BIT];
				end
				default: r_next.hrdata = 32'h0000_0000;
			endcase
		end

		// -------------------------------------------------------------
		// conversion sequence
		// -------------------------------------------------------------
		if (ctrl_ld)
		begin
			r_next.ctrl = ctrl_val;
		end
		sw_go = ctrl_ld & ctrl_val[adc_if_pkg::SOFTWARE_CONVERT_BIT_BIT] & ~ctrl_val[adc_if_pkg::STBY_BIT];
		hw_go = hw_rise & ~r_reg.ctrl[adc_if_pkg::SOFTWARE_CONVERT_BIT_BIT] & ~r_reg.ctrl[adc_if_pkg::STBY_BIT];
		coded = r_reg.ctrl[adc_if_pkg::FMT_BIT] ? {~core_result[adc_if_pkg::RES_W-1], core_result[adc_if_pkg::RES_W-2:0]}
			: core_result;

		unique case (r_reg.conv)
			adc_if_pkg::CS_IDLE:
			begin
				if (sw_go)
				begin
					r_next.conv = adc_if_pkg::CS_ACQ;
					r_next.cnt = acq_cyc - adc_if_pkg::CNT_ONE;
				end
				else if (hw_go)
				begin
					r_next.conv = adc_if_pkg::CS_CONV;
					r_next.cnt = adc_if_pkg::CONV_CYC - adc_if_pkg::CNT_ONE;
				end
			end
			adc_if_pkg::CS_ACQ:
			begin
				if (r_reg.cnt == adc_if_pkg::CNT_ZERO)
				begin
					r_next.conv = adc_if_pkg::CS_CONV;
					r_next.cnt = adc_if_pkg::CONV_CYC - adc_if_pkg::CNT_ONE;
				end
				else
				begin
					r_next.cnt = r_reg.cnt - adc_if_pkg::CNT_ONE;
				end
			end
			adc_if_pkg::CS_CONV:
			begin
				if (r_reg.cnt == adc_if_pkg::CNT_ZERO)
				begin
					r_next.conv = adc_if_pkg::CS_EOC;
					r_next.result = coded;
					r_next.cnt = adc_if_pkg::EOC_CYC - adc_if_pkg::CNT_ONE;
				end
				else
				begin
					r_next.cnt = r_reg.cnt - adc_if_pkg::CNT_ONE;
				end
			end
			adc_if_pkg::CS_EOC:
			begin
				if (r_reg.cnt == adc_if_pkg::CNT_ZERO)
				begin
					r_next.conv = adc_if_pkg::CS_IDLE;
				end
				else
				begin
					r_next.cnt = r_reg.cnt - adc_if_pkg::CNT_ONE;
				end
			end
		endcase
		// entering standby aborts whatever is running
		if (ctrl_ld && ctrl_val[adc_if_pkg::STBY_BIT])
		begin
			r_next.conv = adc_if_pkg::CS_IDLE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			r_reg <= '{conv: adc_if_pkg::CS_IDLE, cnt: adc_if_pkg::CNT_ZERO, ctrl: adc_if_pkg::CTRL_RESET,
				result: 12'h000, sy1: adc_if_pkg::PIN_RESET, sy2: adc_if_pkg::PIN_RESET, sy3: adc_if_pkg::PIN_RESET,
				db_s1: 6'h00, db_s2: 6'h00, db_oe: 1'b0, rd_shift: 16'h0000, rd_cnt: adc_if_pkg::SER_RD_BITS,
				sdo: 1'b0, sdo_oe: 1'b0, wr_shift: 6'h00, wr_cnt: adc_if_pkg::SER_WR_BITS, a_sel: 1'b0,
				a_write: 1'b0, a_addr: 8'h00, hrdata: 32'h0000_0000};
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r_reg.hrdata;
	assign parallel_bus_out = r_reg.result;
	assign parallel_bus_oe = r_reg.db_oe;
	assign serial_data_out = r_reg.sdo;
	assign serial_data_oe = r_reg.sdo_oe;
	assign track_hold = r_reg.conv == adc_if_pkg::CS_CONV;
	assign eoc_n = r_reg.conv != adc_if_pkg::CS_EOC;
	assign power_down = r_reg.ctrl[adc_if_pkg::STBY_BIT];
	assign mux_channel = r_reg.ctrl[adc_if_pkg::CH_MSB:adc_if_pkg::CH_LSB];

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// hold length is the 16-cycle conversion time
	conv_length_a: assert property ($rose(track_hold) |-> ##16 $fell(track_hold))
		else $error("conversion hold length wrong");
	eoc_pulse_a: assert property ($fell(track_hold) && !$past(ctrl_ld) |-> $fell(eoc_n) ##1 eoc_n)
		else $error("end of conversion pulse wrong");
	sw_acq_high_a: assert property (high_range_variant && sw_go && r_reg.conv == adc_if_pkg::CS_IDLE
		|=> !track_hold[*6] ##1 track_hold)
		else $error("software start delay wrong for high range");
	sw_acq_low_a: assert property (!high_range_variant && sw_go && r_reg.conv == adc_if_pkg::CS_IDLE
		|=> !track_hold[*4] ##1 track_hold)
		else $error("software start delay wrong for low range");
	hw_start_a: assert property (hw_go && !ctrl_ld && r_reg.conv == adc_if_pkg::CS_IDLE |=> track_hold)
		else $error("hardware start not taken");
	hw_blocked_a: assert property (hw_rise && r_reg.ctrl[adc_if_pkg::SOFTWARE_CONVERT_BIT_BIT] && !ctrl_ld
		&& r_reg.conv == adc_if_pkg::CS_IDLE |=> !track_hold)
		else $error("hardware start not blocked");
	standby_idle_a: assert property (power_down |-> !track_hold && eoc_n)
		else $error("conversion running in standby");
	par_read_a: assert property (mode_par && !r_reg.sy2[adc_if_pkg::P_CS] && !r_reg.sy2[adc_if_pkg::P_RD]
		|=> parallel_bus_oe && parallel_bus_out == $past(r_reg.result))
		else $error("parallel read not driven");
	par_write_a: assert property (mode_par && wr_rise && !ahb_ctrl_wr
		|=> mux_channel == $past(r_reg.db_s2[adc_if_pkg::CH_MSB:adc_if_pkg::CH_LSB]))
		else $error("parallel channel not captured");
	ser_word_a: assert property (!mode_par && rfs_fall
		|=> r_reg.rd_shift == {$past(r_reg.ctrl[adc_if_pkg::FMT_BIT]), $past(mux_channel), $past(r_reg.result)})
		else $error("serial read word wrong");
	ser_release_a: assert property (!mode_par && sclk_rise && !r_reg.sy2[adc_if_pkg::P_RFS] && !rfs_fall
		&& r_reg.rd_cnt == adc_if_pkg::SER_RD_BITS |=> !serial_data_oe)
		else $error("serial output not released");
	ser_write_a: assert property (!mode_par && sclk_fall && !r_reg.sy2[adc_if_pkg::P_TFS] && !tfs_fall
		&& r_reg.wr_cnt == adc_if_pkg::SER_WR_LAST && !ahb_ctrl_wr
		|=> r_reg.ctrl == $past({r_reg.wr_shift[4:0], r_reg.sy2[adc_if_pkg::P_SDI]}))
		else $error("serial control not loaded");

	sw_conv_c: cover property (sw_go ##[1:30] $fell(eoc_n));
	hw_conv_c: cover property (hw_go ##[1:30] $fell(eoc_n));
	ser_read_c: cover property (!mode_par && sclk_rise && r_reg.rd_cnt == adc_if_pkg::SER_RD_BITS);
	ser_write_c: cover property (!mode_par && ctrl_ld && sclk_fall);
endmodule : adc_conversion_host_interface

//--- include/adc_if_pkg.sv
// shared constants and types of the converter sequencing and host interface block
package adc_if_pkg;
	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int ACQ_HIGH_NS = 600;
	localparam int ACQ_LOW_NS = 400;
	localparam int CONV_NS = 1600;
	localparam int READ_GUARD_NS = 100;
	// least times round up to whole cycles
	localparam logic [4:0] ACQ_HIGH_CYC = 5'((ACQ_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] ACQ_LOW_CYC = 5'((ACQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] CONV_CYC = 5'((CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] EOC_CYC = 5'h01;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [4:0] CNT_ZERO = 5'h00;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] RESULT_OFS = 8'h08;
	localparam int CTRL_W = 6;
	localparam int RES_W = 12;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam int FMT_BIT = 0;
	localparam int STBY_BIT = 1;
	localparam int SOFTWARE_CONVERT_BIT_BIT = 2;
	localparam int CH_LSB = 3;
	localparam int CH_MSB = 5;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_STATE_LSB = 1;
	localparam int ST_STATE_MSB = 2;
	localparam int ST_MODE_BIT = 3;
	localparam int ST_HOLD_BIT = 4;
	localparam int ST_STBY_BIT = 5;

	// -----------------------------------------------------------------
	// serial link
	// -----------------------------------------------------------------
	localparam int SER_RD_W = 16;
	localparam logic [4:0] SER_RD_BITS = 5'h10;
	localparam logic [2:0] SER_WR_LAST = 3'h5;
	localparam logic [2:0] SER_WR_BITS = 3'h6;

	// -----------------------------------------------------------------
	// synchronised pins, one bit each
	// -----------------------------------------------------------------
	localparam int PIN_W = 9;
	localparam int P_START = 0;
	localparam int P_SCLK = 1;
	localparam int P_RFS = 2;
	localparam int P_TFS = 3;
	localparam int P_SDI = 4;
	localparam int P_CS = 5;
	localparam int P_RD = 6;
	localparam int P_WR = 7;
	localparam int P_MODE = 8;
	localparam logic [PIN_W-1:0] PIN_RESET = 9'h1FF;

	typedef enum logic [1:0]
	{
		CS_IDLE = 2'b00,
		CS_ACQ = 2'b01,
		CS_CONV = 2'b10,
		CS_EOC = 2'b11
	} conv_state_t;

	typedef struct packed
	{
		conv_state_t conv;
		logic [4:0] cnt;
		logic [CTRL_W-1:0] ctrl;
		logic [RES_W-1:0] result;
		logic [PIN_W-1:0] sy1;
		logic [PIN_W-1:0] sy2;
		logic [PIN_W-1:0] sy3;
		logic [CTRL_W-1:0] db_s1;
		logic [CTRL_W-1:0] db_s2;
		logic db_oe;
		logic [SER_RD_W-1:0] rd_shift;
		logic [4:0] rd_cnt;
		logic sdo;
		logic sdo_oe;
		logic [CTRL_W-1:0] wr_shift;
		logic [2:0] wr_cnt;
		logic a_sel;
		logic a_write;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
	} state_t;
endpackage : adc_if_pkg

//--- test/host_serial_model.sv
// behavioural host on the five-wire serial link, frames tied together
`timescale 1ns/100ps
module host_serial_model
(
	output logic serial_clock,
	output logic read_frame_n,
	output logic write_frame_n,
	output logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);
	localparam time HALF = 400;
	initial
	begin
		serial_clock = 1'b0;
		read_frame_n = 1'b1;
		write_frame_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// -----------------------------------------------------------------
	// one transfer: reads nb bits, writes six control bits
	// -----------------------------------------------------------------
	task xfer(input logic [5:0] wr, input int nb, output logic [15:0] rd, output logic oe_end);
		int i;
		rd = 16'h0000;
		// odd offset keeps the link out of phase with hclk
		#37;
		read_frame_n = 1'b0;
		write_frame_n = 1'b0;
		#HALF;
		for (i = 0; i < nb; i++)
		begin
			serial_clock = 1'b1;
			// past the sixth bit the line keeps toggling, never a stale level
			serial_data_in = (i < 6) ? wr[5 - i] : ~serial_data_in;
			#HALF;
			rd = {rd[14:0], serial_data_oe ? serial_data_out : 1'bx};
			serial_clock = 1'b0;
			#HALF;
		end
		if (nb == 16)
		begin
			serial_clock = 1'b1;
			#HALF;
			serial_clock = 1'b0;
		end
		else
		begin
			read_frame_n = 1'b1;
			write_frame_n = 1'b1;
			#HALF;
		end
		oe_end = serial_data_oe;
		read_frame_n = 1'b1;
		write_frame_n = 1'b1;
		#HALF;
	endtask : xfer
endmodule : host_serial_model

//--- test/tb_top.sv
// self-checking bench for the converter sequencing and host interface
`timescale 1ns/100ps
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic strap = 1'b1;
	logic hw_start_strobe_n = 1'b1;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [11:0] pbus_in = 12'h000;
	logic [11:0] pbus_out;
	logic pbus_oe;
	logic serial_clock, read_frame_n, write_frame_n, sdi, sdo, sdo_oe;
	logic [11:0] core = 12'h000;
	logic track_hold, eoc_n, power_down;
	logic [2:0] mux_channel;
	int n_fail = 0;
	int check_count = 0;
	logic [5:0] ctrl_m = 6'h00;
	logic [11:0] res_m = 12'h000;
	logic [31:0] rdv;
	logic [15:0] srd;
	logic oe_end;
	logic [5:0] w;
	int n;
	int k;

	always #50 hclk = ~hclk;

	adc_conversion_host_interface i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .interface_mode_strap(strap),
		.hw_start_strobe_n(hw_start_strobe_n), .chip_select_n(cs_n), .read_strobe_n(rd_n),
		.write_strobe_n(wr_n), .parallel_bus_in(pbus_in), .parallel_bus_out(pbus_out),
		.parallel_bus_oe(pbus_oe), .serial_clock(serial_clock), .read_frame_n(read_frame_n),
		.write_frame_n(write_frame_n), .serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_oe(sdo_oe), .core_result(core), .track_hold(track_hold), .eoc_n(eoc_n),
		.power_down(power_down), .mux_channel(mux_channel));

	host_serial_model i_host (.serial_clock(serial_clock), .read_frame_n(read_frame_n),
		.write_frame_n(write_frame_n), .serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_oe(sdo_oe));

	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask : chk

	task end_sim();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	function automatic logic sig(input int s);
		case (s)
			0: return hreadyout;
			1: return track_hold;
			default: return pbus_oe;
		endcase
	endfunction : sig

	task waitfor(input int s, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge hclk);
			cnt++;
		end
		while (sig(s) !== lvl && cnt < lim);
		if (sig(s) !== lvl)
		begin
			chk("wait bound", 32'h1, 32'h0);
			end_sim();
		end
	endtask : waitfor

	task ahb(input logic wrt, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int c;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wrt;
		waitfor(0, 1'b1, 50, c);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitfor(0, 1'b1, 50, c);
		r = hrdata;
		chk("hresp", 32'h0, 32'(hresp));
	endtask : ahb

	task no_start(input string nm);
		int c;
		c = 0;
		hw_start_strobe_n <= 1'b0;
		repeat (2) @(posedge hclk);
		hw_start_strobe_n <= 1'b1;
		repeat (30)
		begin
			@(posedge hclk);
			c += int'(track_hold === 1'b1);
		end
		chk(nm, 32'h0, 32'(c));
	endtask : no_start

	task wctrl();
		ahb(1'b1, adc_if_pkg::CTRL_OFS, 32'(ctrl_m), rdv);
	endtask : wctrl

	task conv(input logic hw);
		core <= 12'($urandom);
		if (hw)
		begin
			// settle after channel change or last conversion before the next start
			repeat (adc_if_pkg::ACQ_HIGH_CYC) @(posedge hclk);
			hw_start_strobe_n <= 1'b0;
			repeat (2) @(posedge hclk);
			hw_start_strobe_n <= 1'b1;
			waitfor(1, 1'b1, 20, n);
			chk("start latency", 32'h1, 32'(n <= 4));
		end
		else
		begin
			ctrl_m[2] = 1'b1;
			wctrl();
			waitfor(1, 1'b1, 20, n);
			chk("acq delay", 32'h1, 32'(n >= 6 && n <= 7));
		end
		waitfor(1, 1'b0, 40, n);
		chk("conv cycles", 32'(adc_if_pkg::CONV_CYC), 32'(n));
		chk("eoc low", 32'h0, 32'(eoc_n));
		res_m = ctrl_m[0] ? {~core[11], core[10:0]} : core;
		@(posedge hclk);
		chk("eoc back", 32'h1, 32'(eoc_n));
		ahb(1'b0, adc_if_pkg::RESULT_OFS, 32'h0, rdv);
		chk("result", 32'(res_m), rdv);
	endtask : conv

	task pwrite(input logic [5:0] v);
		pbus_in <= {6'h00, v};
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		repeat (4) @(posedge hclk);
		wr_n <= 1'b1;
		repeat (4) @(posedge hclk);
		cs_n <= 1'b1;
		repeat (2) @(posedge hclk);
	endtask : pwrite

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		n = $urandom(70832);
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("idle", 32'h1, 32'({track_hold, power_down, eoc_n}));
		ahb(1'b0, adc_if_pkg::CTRL_OFS, 32'h0, rdv);
		chk("ctrl reset", 32'h0, rdv);
		ahb(1'b0, 8'h0C, 32'h0, rdv);
		chk("unmapped", 32'h0, rdv);
		for (k = 0; k < 2; k++)
		begin
			ctrl_m = {3'($urandom), 2'b00, k[0]};
			wctrl();
			ahb(1'b0, adc_if_pkg::CTRL_OFS, 32'h0, rdv);
			chk("ctrl", 32'(ctrl_m), rdv);
			chk("channel", 32'(ctrl_m[5:3]), 32'(mux_channel));
			conv(1'b1);
		end
		conv(1'b0);
		no_start("hw start masked");
		ctrl_m[2] = 1'b0;
		wctrl();
		conv(1'b1);
		ctrl_m[1] = 1'b1;
		wctrl();
		@(posedge hclk);
		chk("standby", 32'h1, 32'(power_down));
		ahb(1'b0, adc_if_pkg::STATUS_OFS, 32'h0, rdv);
		chk("status", 32'(1 << adc_if_pkg::ST_STBY_BIT | 1 << adc_if_pkg::ST_MODE_BIT), rdv);
		no_start("standby start");
		ctrl_m[1] = 1'b0;
		wctrl();
		@(posedge hclk);
		chk("awake", 32'h0, 32'(power_down));
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		waitfor(2, 1'b1, 10, n);
		chk("bus read", 32'(res_m), 32'(pbus_out));
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		waitfor(2, 1'b0, 10, n);
		ctrl_m = {3'($urandom), 2'b00, ctrl_m[0]};
		pwrite(ctrl_m);
		chk("bus channel", 32'(ctrl_m[5:3]), 32'(mux_channel));
		strap <= 1'b0;
		repeat (4) @(posedge hclk);
		pwrite(~ctrl_m & 6'h38);
		chk("bus ignored", 32'(ctrl_m[5:3]), 32'(mux_channel));
		conv(1'b1);
		w = {3'($urandom), 2'b00, ctrl_m[0]};
		i_host.xfer(w, 16, srd, oe_end);
		@(posedge hclk);
		chk("serial read", 32'({ctrl_m[0], ctrl_m[5:3], res_m}), 32'(srd));
		chk("release clock", 32'h0, 32'(oe_end));
		ctrl_m = w;
		chk("serial channel", 32'(w[5:3]), 32'(mux_channel));
		w = {3'($urandom), 2'b00, ctrl_m[0]};
		i_host.xfer(w, 8, srd, oe_end);
		@(posedge hclk);
		chk("part read", 32'({ctrl_m[0], ctrl_m[5:3], res_m[11:8]}), 32'(srd[7:0]));
		chk("release frame", 32'h0, 32'(oe_end));
		chk("extra bits", 32'(w[5:3]), 32'(mux_channel));
		end_sim();
	end
endmodule : tb_top
